// ---- src/lfts_supervisor.sv ----
// Purpose: Channel fault time-outs, thermal halt and step-down, power-up short latch.
// Assumes: All sense inputs are asynchronous comparator levels.
// Notes: Analog loops live outside; this block only gates them.
`timescale 1ns/100ps
`include "lfts_defs.svh"
module lfts_supervisor
  import lfts_pkg::*;
#(
  parameter int unsigned HOT_CYC = `LFTS_HOT_TO_CYC,
  parameter int unsigned POR_CYC = `LFTS_POR_CYC,
  parameter int unsigned PWM_TO = `LFTS_PWM_TO
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic enable_i,
  input wire logic pwm_i,
  input wire logic temp_low_i,
  input wire logic temp_high_i,
  input wire logic temp_cool_i,
  input wire logic output_overvoltage_limit_i,
  input wire logic ovsense_low_i,
  input wire logic switch_node_short_i,
  input wire logic [`LFTS_NCH-1:0] sink_high_i,
  input wire logic [`LFTS_NCH-1:0] current_good_i,
  output logic [`LFTS_NCH-1:0] channel_on_o,
  output logic [`LFTS_NCH-1:0] channel_disabled_o,
  output logic boost_on_o,
  output logic active_o,
  output logic thermal_halt_o,
  output logic shutdown_latched_o,
  output logic [1:0] current_step_o,
  output logic [6:0] current_pct_o
);

  localparam int NCH = `LFTS_NCH;
  localparam int SW = $bits(lfts_pins_t);
  localparam int HW = $clog2(HOT_CYC + 1);
  localparam int PCW = $clog2(PWM_TO + 1);
  localparam int RW = $clog2(POR_CYC + 1);
  localparam logic [HW-1:0] HOT_LAST = HW'(HOT_CYC - 1);
  localparam logic [PCW-1:0] PWM_LAST = PCW'(PWM_TO - 1);
  localparam logic [RW-1:0] POR_LAST = RW'(POR_CYC - 1);

  // Input synchroniser: three stages, accept a change when stages two and three agree
  logic [SW-1:0] raw;
  logic [SW-1:0] s1_q, s2_q, s3_q, filt_q;
  logic [SW-1:0] s1_d, s2_d, s3_d, filt_d;
  lfts_pins_t pins;

  assign raw = {enable_i, pwm_i, temp_low_i, temp_high_i, temp_cool_i,
                output_overvoltage_limit_i, ovsense_low_i, switch_node_short_i,
                sink_high_i, current_good_i};

  always_comb begin
    s1_d = raw;
    s2_d = s1_q;
    s3_d = s2_q;
    filt_d = (s2_q & s3_q) | (filt_q & (s2_q | s3_q));
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      filt_q <= '0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      filt_q <= filt_d;
    end
  end

  assign pins = lfts_pins_t'(filt_q);

  // PWM period edge, the time base of the short and open time-outs
  logic pwm_prev_q, pwm_prev_d;
  logic pwm_rise;

  always_comb begin
    pwm_prev_d = pins.pwm;
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      pwm_prev_q <= 1'b0;
    end else begin
      pwm_prev_q <= pwm_prev_d;
    end
  end

  assign pwm_rise = pins.pwm & ~pwm_prev_q;

  // Supervisor state, current step and power-up short watch
  lfts_state_t state_q, state_d;
  logic [1:0] step_q, step_d;
  logic [RW-1:0] por_cnt_q, por_cnt_d;
  logic por_done_q, por_done_d;
  logic sw_seen_q, sw_seen_d;
  logic ov_rose_q, ov_rose_d;
  logic short_trip;

  // A sense node that rose and then collapsed is a short, whenever it happens
  assign short_trip = ov_rose_q & pins.ovsense_low;

  always_comb begin
    state_d = state_q;
    step_d = step_q;
    por_cnt_d = por_cnt_q;
    por_done_d = por_done_q;
    sw_seen_d = sw_seen_q | pins.switch_node_short;
    ov_rose_d = ov_rose_q | ~pins.ovsense_low;
    if (state_q != LFTS_ST_OFF && !por_done_q) begin
      por_cnt_d = por_cnt_q + RW'(1);
      if (por_cnt_q == POR_LAST) begin
        por_done_d = 1'b1;
      end
    end
    case (state_q)
      LFTS_ST_OFF: begin
        step_d = `LFTS_STEP_RST;
        por_cnt_d = '0;
        por_done_d = 1'b0;
        sw_seen_d = 1'b0;
        ov_rose_d = 1'b0;
        if (pins.enable) begin
          state_d = LFTS_ST_RUN;
        end
      end
      LFTS_ST_RUN: begin
        if (pins.temp_high) begin
          state_d = LFTS_ST_HALT;
          if (step_q != `LFTS_STEP_MAX) begin
            step_d = step_q + 2'h1;
          end
        end
      end
      LFTS_ST_HALT: begin
        // Restart at the next step down once cool; stays active unless enable drops or a short latches
        if (pins.temp_cool && !pins.temp_high) begin
          state_d = LFTS_ST_RUN;
        end
      end
      LFTS_ST_LATCH: begin
        state_d = LFTS_ST_LATCH;
      end
      default: begin
        state_d = LFTS_ST_OFF;
      end
    endcase
    if (state_q == LFTS_ST_RUN || state_q == LFTS_ST_HALT) begin
      if (!por_done_q && por_cnt_q == POR_LAST) begin
        if (sw_seen_d || pins.ovsense_low) begin
          state_d = LFTS_ST_LATCH;
        end
      end
      if (short_trip) begin
        state_d = LFTS_ST_LATCH;
      end
    end
    if (!pins.enable) begin
      state_d = LFTS_ST_OFF;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      state_q <= LFTS_ST_OFF;
      step_q <= `LFTS_STEP_RST;
      por_cnt_q <= '0;
      por_done_q <= 1'b0;
      sw_seen_q <= 1'b0;
      ov_rose_q <= 1'b0;
    end else begin
      state_q <= state_d;
      step_q <= step_d;
      por_cnt_q <= por_cnt_d;
      por_done_q <= por_done_d;
      sw_seen_q <= sw_seen_d;
      ov_rose_q <= ov_rose_d;
    end
  end

  // Per-channel fault tracking; no channel looks at another's state
  logic [NCH-1:0] dis_q;
  logic run;

  assign run = (state_q == LFTS_ST_RUN);

  generate
    for (genvar i = 0; i < NCH; i++) begin : g_ch
      logic good_q, good_d;
      logic dis_d;
      logic [PCW-1:0] pcnt_q, pcnt_d;
      logic [HW-1:0] tcnt_q, tcnt_d;
      logic open_c;
      logic short_c;

      // Below target counts as open once good, or at over-voltage or lower trip
      assign open_c = ~pins.current_good[i] &
                      (good_q | pins.output_overvoltage_limit | pins.temp_low);
      // Only the 4 V comparator marks a short; a lower sink keeps driving
      assign short_c = pins.sink_high[i];

      always_comb begin
        good_d = good_q;
        dis_d = dis_q[i];
        pcnt_d = pcnt_q;
        tcnt_d = tcnt_q;
        if (state_q == LFTS_ST_OFF) begin
          good_d = 1'b0;
          dis_d = 1'b0;
          pcnt_d = '0;
          tcnt_d = '0;
        end else if (!run || dis_q[i]) begin
          // Halted current sources read as low current; do not judge them
          pcnt_d = '0;
          tcnt_d = '0;
        end else begin
          if (pins.current_good[i]) begin
            good_d = 1'b1;
          end
          if (open_c || short_c) begin
            if (pwm_rise) begin
              pcnt_d = pcnt_q + PCW'(1);
              if (pcnt_q == PWM_LAST) begin
                dis_d = 1'b1;
              end
            end
          end else begin
            pcnt_d = '0;
          end
          // Faster fixed time-out while hot, to stay clear of the upper trip
          if (open_c && pins.temp_low) begin
            tcnt_d = tcnt_q + HW'(1);
            if (tcnt_q == HOT_LAST) begin
              dis_d = 1'b1;
            end
          end else begin
            tcnt_d = '0;
          end
        end
      end

      always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
          good_q <= 1'b0;
          dis_q[i] <= 1'b0;
          pcnt_q <= '0;
          tcnt_q <= '0;
        end else begin
          good_q <= good_d;
          dis_q[i] <= dis_d;
          pcnt_q <= pcnt_d;
          tcnt_q <= tcnt_d;
        end
      end
    end
  endgenerate

  // Registered outputs
  logic [NCH-1:0] ch_on_q, ch_on_d;
  logic boost_q, boost_d;
  logic active_q, active_d;
  logic halt_q, halt_d;
  logic latch_q, latch_d;
  logic [6:0] pct_q, pct_d;

  always_comb begin
    ch_on_d = run ? ~dis_q : '0;
    boost_d = run;
    active_d = (state_q == LFTS_ST_RUN) || (state_q == LFTS_ST_HALT);
    halt_d = (state_q == LFTS_ST_HALT);
    latch_d = (state_q == LFTS_ST_LATCH);
    case (step_q)
      2'h0: pct_d = `LFTS_PCT_FULL;
      2'h1: pct_d = `LFTS_PCT_75;
      2'h2: pct_d = `LFTS_PCT_50;
      2'h3: pct_d = `LFTS_PCT_25;
      default: pct_d = `LFTS_PCT_FULL;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      ch_on_q <= '0;
      boost_q <= 1'b0;
      active_q <= 1'b0;
      halt_q <= 1'b0;
      latch_q <= 1'b0;
      pct_q <= `LFTS_PCT_FULL;
    end else begin
      ch_on_q <= ch_on_d;
      boost_q <= boost_d;
      active_q <= active_d;
      halt_q <= halt_d;
      latch_q <= latch_d;
      pct_q <= pct_d;
    end
  end

  assign channel_on_o = ch_on_q;
  assign channel_disabled_o = dis_q;
  assign boost_on_o = boost_q;
  assign active_o = active_q;
  assign thermal_halt_o = halt_q;
  assign shutdown_latched_o = latch_q;
  assign current_step_o = step_q;
  assign current_pct_o = pct_q;

endmodule : lfts_supervisor

// ---- src/lfts_defs.svh ----
// Purpose: Constants for the LED fault and thermal supervisor.
// Assumes: 40 MHz core clock.
// Notes: Timing counts are derived from the printed times.
`ifndef LFTS_DEFS_SVH
`define LFTS_DEFS_SVH
`define LFTS_NCH 6
`define LFTS_CLK_HZ 40000000
`define LFTS_HOT_TO_US 800
`define LFTS_HOT_TO_CYC (`LFTS_HOT_TO_US * (`LFTS_CLK_HZ / 1000000))
`define LFTS_POR_MS 31
`define LFTS_POR_CYC (`LFTS_POR_MS * (`LFTS_CLK_HZ / 1000))
`define LFTS_PWM_TO 6
`define LFTS_STEP_RST 2'h0
`define LFTS_STEP_MAX 2'h3
`define LFTS_PCT_FULL 7'h64
`define LFTS_PCT_75 7'h4B
`define LFTS_PCT_50 7'h32
`define LFTS_PCT_25 7'h19
`endif

// ---- src/lfts_pkg.sv ----
// Purpose: Types for the LED fault and thermal supervisor.
// Assumes: lfts_defs.svh supplies the channel count.
// Notes: Pin group order is fixed; the synchroniser treats it as a vector.
`include "lfts_defs.svh"
package lfts_pkg;
  typedef struct packed {
    logic enable;
    logic pwm;
    logic temp_low;
    logic temp_high;
    logic temp_cool;
    logic output_overvoltage_limit;
    logic ovsense_low;
    logic switch_node_short;
    logic [`LFTS_NCH-1:0] sink_high;
    logic [`LFTS_NCH-1:0] current_good;
  } lfts_pins_t;

  typedef enum logic [3:0] {
    LFTS_ST_OFF = 4'b0001,
    LFTS_ST_RUN = 4'b0010,
    LFTS_ST_HALT = 4'b0100,
    LFTS_ST_LATCH = 4'b1000
  } lfts_state_t;
endpackage : lfts_pkg

// ---- verification/lfts_supervisor_sva.sv ----
// Purpose: Port checks for the LED fault supervisor.
// Assumes: Checks sleep while reset is low.
// Notes: Bound to every supervisor instance.
`timescale 1ns/100ps
`include "lfts_defs.svh"
module lfts_supervisor_chk (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic enable_i,
  input wire logic [`LFTS_NCH-1:0] channel_on_o,
  input wire logic [`LFTS_NCH-1:0] channel_disabled_o,
  input wire logic boost_on_o,
  input wire logic active_o,
  input wire logic thermal_halt_o,
  input wire logic shutdown_latched_o,
  input wire logic [1:0] current_step_o,
  input wire logic [6:0] current_pct_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);
  logic [6:0] pct_w;
  assign pct_w = current_step_o == 2'h0 ? `LFTS_PCT_FULL : current_step_o == 2'h1 ?
    `LFTS_PCT_75 : current_step_o == 2'h2 ? `LFTS_PCT_50 : `LFTS_PCT_25;
  sequence en_held;
    enable_i [*8];
  endsequence
  sequence halt_entry;
    !thermal_halt_o ##1 thermal_halt_o;
  endsequence
  chk_halt_stops_boost: assert property (
    thermal_halt_o |-> !boost_on_o && channel_on_o == 6'h00) else $error("on in halt");
  chk_halt_stays_active: assert property (
    thermal_halt_o |-> active_o) else $error("halt not active");
  // The percentage register trails the step count by one clock
  chk_pct_follows_step: assert property (
    boost_on_o |-> current_pct_o == $past(pct_w)) else $error("pct wrong");
  chk_step_never_falls: assert property (
    active_o && $past(active_o) |-> current_step_o >= $past(current_step_o))
    else $error("step fell");
  chk_halt_counts_step: assert property (
    halt_entry |-> current_step_o != 2'h0) else $error("step not counted");
  chk_disabled_goes_off: assert property (
    (channel_on_o & $past(channel_disabled_o)) == 6'h00) else $error("disabled channel on");
  chk_flags_stay_set: assert property (
    en_held |=> (channel_disabled_o & $past(channel_disabled_o)) == $past(channel_disabled_o))
    else $error("flag cleared");
  chk_latch_all_off: assert property (
    shutdown_latched_o |-> !active_o && !boost_on_o && channel_on_o == 6'h00)
    else $error("on in latch");
endmodule : lfts_supervisor_chk
bind lfts_supervisor lfts_supervisor_chk chk_u (.clock_i, .resetn_i, .enable_i,
  .channel_on_o, .channel_disabled_o, .boost_on_o, .active_o, .thermal_halt_o,
  .shutdown_latched_o, .current_step_o, .current_pct_o);

// ---- verification/lfts_far_side.sv ----
// Purpose: Far side: PWM source and six LED strings.
// Assumes: A string answers its current source one clock later.
// Notes: An open string never reaches target current.
`timescale 1ns/100ps
module lfts_far_side #(
  parameter int PERIOD = 20
) (
  input wire logic clock_i,
  input wire logic pwm_run_i,
  input wire logic [5:0] open_mask_i,
  input wire logic [5:0] short_mask_i,
  input wire logic [5:0] channel_on_i,
  output logic pwm_o,
  output logic [5:0] sink_high_o,
  output logic [5:0] current_good_o
);
  int cnt_q;
  always_ff @(posedge clock_i) begin
    cnt_q <= (cnt_q >= PERIOD - 1) ? 0 : cnt_q + 1;
    pwm_o <= pwm_run_i && (cnt_q < PERIOD / 2);
    current_good_o <= channel_on_i & ~open_mask_i;
    sink_high_o <= short_mask_i;
  end
endmodule : lfts_far_side

// ---- verification/lfts_supervisor_bench.sv ----
// Purpose: Self-checking bench for the LED fault supervisor.
// Assumes: Short time-outs; far side PWM period is 20 clocks.
// Notes: Enable drops between scenarios to clear latched state.
`timescale 1ns/100ps
`include "lfts_defs.svh"
module lfts_supervisor_bench;
  import lfts_pkg::*;
  localparam int PER = 20;
  logic clock_i, resetn_i, enable_i, temp_low_i, temp_high_i, temp_cool_i, run;
  logic output_overvoltage_limit_i, switch_node_short_i, pwm_i, boost_on_o, active_o;
  logic thermal_halt_o, shutdown_latched_o, ovsense_low_i;
  logic [5:0] open_m, short_m, sink_high_i, current_good_i, channel_on_o, channel_disabled_o;
  logic [1:0] current_step_o;
  logic [6:0] current_pct_o;
  int errors, num_checks;
  lfts_supervisor #(.HOT_CYC(20), .POR_CYC(50), .PWM_TO(6)) dut_u (.clock_i, .resetn_i,
    .enable_i, .pwm_i, .temp_low_i, .temp_high_i, .temp_cool_i, .output_overvoltage_limit_i,
    .ovsense_low_i, .switch_node_short_i, .sink_high_i, .current_good_i, .channel_on_o,
    .channel_disabled_o, .boost_on_o, .active_o, .thermal_halt_o, .shutdown_latched_o,
    .current_step_o, .current_pct_o);
  lfts_far_side #(.PERIOD(PER)) far_u (.clock_i, .pwm_run_i(run), .open_mask_i(open_m),
    .short_mask_i(short_m), .channel_on_i(channel_on_o), .pwm_o(pwm_i),
    .sink_high_o(sink_high_i), .current_good_o(current_good_i));
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  task automatic report_and_stop();
    if (errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(string what, logic [6:0] seen, logic [6:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tick(int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : tick
  // Bit sel of {latch, halt clear, halt, flags}; running out ends the run
  task automatic wait_for(int sel, int lim);
    logic [8:0] seen;
    seen = 9'h000;
    for (int i = 0; i < lim && seen[sel] !== 1'b1; i++) begin
      tick(1);
      seen = {shutdown_latched_o, ~thermal_halt_o, thermal_halt_o, channel_disabled_o};
    end
    if (seen[sel] !== 1'b1) begin
      chk("wait", 7'h00, 7'h01);
      report_and_stop();
    end
  endtask : wait_for
  task automatic restart(logic [5:0] open_v, logic sw_v);
    @(posedge clock_i);
    enable_i <= 1'b0;
    {temp_low_i, temp_high_i, temp_cool_i, output_overvoltage_limit_i, short_m} <= 10'h000;
    open_m <= open_v;
    switch_node_short_i <= sw_v;
    run <= 1'b1;
    tick(10);
    @(posedge clock_i);
    enable_i <= 1'b1;
    tick(12);
  endtask : restart
  task automatic s_sink();
    restart(6'h00, 1'b0);
    chk("pct", current_pct_o, `LFTS_PCT_FULL);
    @(posedge clock_i);
    short_m <= 6'h01;
    tick(4 * PER);
    chk("early", channel_disabled_o, 7'h00);
    wait_for(0, 4 * PER);
    tick(2);
    chk("on", channel_on_o, 7'h3E);
    @(posedge clock_i);
    short_m <= 6'h00;
    tick(10 * PER);
    chk("held", channel_disabled_o, 7'h01);
  endtask : s_sink
  task automatic s_open();
    restart(6'h08, 1'b0);
    @(posedge clock_i);
    open_m <= 6'h0A;
    wait_for(1, 8 * PER);
    chk("open", channel_disabled_o, 7'h02);
    @(posedge clock_i);
    output_overvoltage_limit_i <= 1'b1;
    wait_for(3, 8 * PER);
    tick(2);
    chk("on", channel_on_o, 7'h35);
  endtask : s_open
  task automatic s_hot();
    restart(6'h10, 1'b0);
    @(posedge clock_i);
    run <= 1'b0;
    temp_low_i <= 1'b1;
    wait_for(4, 40);
    chk("hot", channel_disabled_o, 7'h10);
  endtask : s_hot
  task automatic s_therm();
    logic [6:0] want [4];
    want = '{`LFTS_PCT_75, `LFTS_PCT_50, `LFTS_PCT_25, `LFTS_PCT_25};
    restart(6'h00, 1'b0);
    // No fault pins: channels at target current must ride out many PWM periods
    tick(8 * PER);
    chk("quiet", channel_disabled_o, 7'h00);
    for (int k = 0; k < 4; k++) begin
      @(posedge clock_i);
      temp_high_i <= 1'b1;
      wait_for(6, 20);
      tick(2);
      chk("halt", {boost_on_o, channel_on_o}, 7'h00);
      chk("active", active_o, 7'h01);
      @(posedge clock_i);
      temp_high_i <= 1'b0;
      temp_cool_i <= 1'b1;
      wait_for(7, 20);
      @(posedge clock_i);
      temp_cool_i <= 1'b0;
      tick(3);
      chk("pct", current_pct_o, want[k]);
      chk("step", current_step_o, (k < 3) ? 7'(k + 1) : 7'h03);
    end
  endtask : s_therm
  task automatic s_latch();
    restart(6'h00, 1'b1);
    wait_for(8, 100);
    chk("active", active_o, 7'h00);
  endtask : s_latch
  task automatic s_sense();
    restart(6'h00, 1'b0);
    tick(3 * PER);
    chk("por", active_o, 7'h01);
    @(posedge clock_i);
    ovsense_low_i <= 1'b1;
    wait_for(8, 20);
    chk("boost", boost_on_o, 7'h00);
    // Sense node held low through power-up: latch at the end of the window
    restart(6'h00, 1'b0);
    chk("unlatch", shutdown_latched_o, 7'h00);
    wait_for(8, 100);
    chk("on", channel_on_o, 7'h00);
  endtask : s_sense
  initial begin
    {resetn_i, enable_i, temp_low_i, temp_high_i, temp_cool_i, run} = 6'h00;
    {output_overvoltage_limit_i, switch_node_short_i, open_m, short_m} = 14'h0000;
    errors = 0;
    ovsense_low_i = 1'b0;
    num_checks = 0;
    repeat (6) @(posedge clock_i);
    resetn_i <= 1'b1;
    s_sink();
    s_open();
    s_hot();
    s_therm();
    s_latch();
    s_sense();
    report_and_stop();
  end
endmodule : lfts_supervisor_bench
